//--- src/nvm_pkg.sv
// constants, pin and bus carriers and the state record of the parallel programming port
// assumes a single 25 MHz pclk domain; pin groups arrive unsynchronised
package nvm_pkg;

	localparam int CLK_MHZ = 25;

	// self-timed busy windows, figures in ms, aimed at the middle of each window
	localparam real WRITE_MIN_MS = 3.7;
	localparam real WRITE_MAX_MS = 4.5;
	localparam real ERASE_MIN_MS = 7.5;
	localparam real ERASE_MAX_MS = 9.0;
	localparam int  WRITE_BUSY_CYCLES = int'((WRITE_MIN_MS + WRITE_MAX_MS) * 500.0 * CLK_MHZ);
	localparam int  ERASE_BUSY_CYCLES = int'((ERASE_MIN_MS + ERASE_MAX_MS) * 500.0 * CLK_MHZ);
	localparam int  CNT_W             = 18;

	// action select codes
	localparam logic [1:0] ACT_ADDR = 2'h0;
	localparam logic [1:0] ACT_DATA = 2'h1;
	localparam logic [1:0] ACT_CMD  = 2'h2;

	// byte select pair codes {byte_select_2, byte_select_1}
	localparam logic [1:0] BSP_LOW  = 2'h0;
	localparam logic [1:0] BSP_HIGH = 2'h1;
	localparam logic [1:0] BSP_EXT  = 2'h2;
	localparam logic [1:0] BSP_ALT  = 2'h3;

	// command bytes
	localparam logic [7:0] CMD_NOP      = 8'h00;
	localparam logic [7:0] CMD_ERASE    = 8'h80;
	localparam logic [7:0] CMD_FUSE_WR  = 8'h40;
	localparam logic [7:0] CMD_LOCK_WR  = 8'h20;
	localparam logic [7:0] CMD_FLASH_WR = 8'h10;
	localparam logic [7:0] CMD_EE_WR    = 8'h11;
	localparam logic [7:0] CMD_SIG_RD   = 8'h08;
	localparam logic [7:0] CMD_FUSE_RD  = 8'h04;
	localparam logic [7:0] CMD_FLASH_RD = 8'h02;
	localparam logic [7:0] CMD_EE_RD    = 8'h03;

	// lock byte layout: general lock bits and boot lock bits
	localparam int LOCK_GEN_LSB  = 0;
	localparam int LOCK_GEN_MSB  = 1;
	localparam int LOCK_BOOT_LSB = 2;
	localparam int LOCK_BOOT_MSB = 5;

	localparam logic [7:0]  FUSE_LO_RESET  = 8'hFF;
	localparam logic [7:0]  FUSE_HI_RESET  = 8'hFF;
	localparam logic [7:0]  FUSE_EXT_RESET = 8'hFF;
	localparam logic [7:0]  LOCK_RESET     = 8'hFF;
	localparam logic [7:0]  CALIB_RESET    = 8'h80;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
	localparam logic [15:0] ERASED_WORD    = 16'hFFFF;

	// register map
	localparam int          APB_AW       = 12;
	localparam logic [11:0] REG_CTRL     = 12'h000;
	localparam logic [11:0] REG_STATUS   = 12'h004;
	localparam logic [11:0] REG_FUSES    = 12'h008;
	localparam logic [11:0] REG_CALIB    = 12'h00C;
	localparam int          CTRL_EN_BIT  = 0;
	localparam logic        CTRL_EN_RESET = 1'b1;

	typedef struct packed {
		logic              psel;
		logic              penable;
		logic              pwrite;
		logic [APB_AW-1:0] paddr;
		logic [31:0]       pwdata;
	} apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic       action_strobe;
		logic       action_sel_hi;
		logic       action_sel_lo;
		logic       byte_select_2;
		logic       byte_select_1;
		logic       page_latch_strobe;
		logic       prog_strobe_n;
		logic       output_enable_n;
		logic [7:0] data_in;
	} pins_t;

	typedef enum logic [2:0] {
		OP_IDLE  = 3'b000,
		OP_FLASH = 3'b001,
		OP_EE    = 3'b010,
		OP_FUSE  = 3'b011,
		OP_LOCK  = 3'b100,
		OP_ERASE = 3'b101
	} op_t;

	typedef struct packed {
		pins_t            s1;
		pins_t            s2;
		logic             prev_strobe;
		logic             prev_latch;
		logic             prev_prog_n;
		logic [7:0]       cmd;
		logic             armed;
		logic [7:0]       addr_lo;
		logic [7:0]       addr_hi;
		logic [7:0]       addr_ext;
		logic [7:0]       data_lo;
		logic [7:0]       data_hi;
		logic             busy;
		op_t              op;
		logic [CNT_W-1:0] cnt;
		logic [CNT_W-1:0] limit;
		logic [7:0]       fuse_lo;
		logic [7:0]       fuse_hi;
		logic [7:0]       fuse_ext;
		logic [7:0]       lock;
		logic [7:0]       calib;
		logic             enable;
		logic [7:0]       dout;
		logic             doe_n;
		logic [31:0]      prdata;
	} state_t;

	// synchroniser stages start with strobes and enables at their idle levels (action select at 00) so no false edge follows reset
	localparam pins_t PINS_IDLE = '{prog_strobe_n: 1'b1, output_enable_n: 1'b1, default: '0};

	localparam state_t STATE_RESET = '{
		s1: PINS_IDLE, s2: PINS_IDLE, prev_strobe: 1'b0, prev_latch: 1'b0, prev_prog_n: 1'b1,
		cmd: CMD_NOP, armed: 1'b0, addr_lo: '0, addr_hi: '0, addr_ext: '0,
		data_lo: '0, data_hi: '0, busy: 1'b0, op: OP_IDLE, cnt: '0, limit: '0,
		fuse_lo: FUSE_LO_RESET, fuse_hi: FUSE_HI_RESET, fuse_ext: FUSE_EXT_RESET,
		lock: LOCK_RESET, calib: CALIB_RESET, enable: CTRL_EN_RESET,
		dout: '0, doe_n: 1'b1, prdata: '0
	};

endpackage

//--- src/parallel_nvm_programming_port.sv
// parallel high-voltage programming port: command/address/data loading, page buffers,
// self-timed flash, eeprom, fuse and lock writes, chip erase and read-back.
// assumes the programmer strobes are far slower than pclk and an APB master on pclk.
//
// Overview of operation
// R1 - action select 00 with byte pair 01 loads address bits 15..8
// R2 - action select 00 with byte pair 10 loads extended address bits 23..16
// R3 - after write-flash, program strobe low with pair 00 writes page, busy
// R4 - programmer repeats address, data, latch and page program until flash done
// R5 - command 0000 0000 is no operation and clears internal write arming
// R6 - eeprom write: command 0001 0001, latch bytes, program strobe writes page
// R7 - programmer waits for ready before starting the next eeprom page
// R8 - flash read drives word low byte at select 0, high byte at 1
// R9 - eeprom read drives addressed byte while output enable low
// R10 - fuse write: data byte, pair 00/01/10 picks low/high/extended fuse
// R11 - lock write: zero bits program locks, committed by program strobe
// R12 - with both general locks programmed, boot lock bits cannot be programmed
// R13 - lock bits return to erased only through chip erase; presetn also reloads LOCK_RESET
// R14 - fuse/lock read: pair 00 low, 11 high, 10 extended, 01 locks
// R15 - signature read: address low 0..2 selects identification byte, select 0
// R16 - signature command, address 0, select 1 reads the calibration byte
// R17 - ready falls within 1 us after program strobe falls
// R18 - flash, eeprom, fuse and lock writes stay busy 3.7 to 4.5 ms
// R19 - chip erase stays busy 7.5 to 9 ms
// R20 - data bus driven only while output enable low, released within 250 ns
// R21 - action select 00 address, 01 data, 10 command, 11 idle
// R22 - page latch pulse with select 1 high copies data into page buffer
// R23 - loaded command and address are held across successive operations
// R24 - word-in-page index is address bits 6..0, upper bits pick page
// R25 - programmer gives no strobes while busy
// R26 - ready stays high whenever no self-timed operation runs
//
// The APB interface to the registers and the register addresses were decided locally.
module parallel_nvm_programming_port #(
	parameter int         FLASH_AW     = 16,
	parameter int         EE_AW        = 12,
	parameter int         PAGE_AW      = 7,
	parameter int         EE_PAGE_AW   = 3,
	parameter int         WRITE_CYCLES = nvm_pkg::WRITE_BUSY_CYCLES,
	parameter int         ERASE_CYCLES = nvm_pkg::ERASE_BUSY_CYCLES,
	parameter logic [7:0] SIG_BYTE0    = 8'h5A, // arbitrary value
	parameter logic [7:0] SIG_BYTE1    = 8'hA5, // arbitrary value
	parameter logic [7:0] SIG_BYTE2    = 8'h3C  // arbitrary value
) (
	input  logic              pclk,
	input  logic              presetn,
	input  logic              clk_en,
	input  nvm_pkg::apb_req_t apb_req,
	output nvm_pkg::apb_rsp_t apb_rsp,
	input  nvm_pkg::pins_t    pins,
	output logic [7:0]        data_out,
	output logic              data_oe_n,
	output logic              ready_busy
);
	import nvm_pkg::*;

	state_t q;
	state_t next_q;

	logic [15:0] flash_mem [2**FLASH_AW];
	logic [7:0]  ee_mem    [2**EE_AW];
	logic [15:0] page_buf  [2**PAGE_AW];
	logic [7:0]  ee_buf    [2**EE_PAGE_AW];

	logic [23:0]         full_addr;
	logic [FLASH_AW-1:0] waddr;
	logic [EE_AW-1:0]    eaddr;
	logic [FLASH_AW-1:0] walk_waddr;
	logic [EE_AW-1:0]    walk_eaddr;
	logic [1:0]          act;
	logic [1:0]          bsp;
	logic [7:0]          din;
	logic                strobe_rise;
	logic                latch_rise;
	logic                prog_fall;
	logic                live;
	logic                flash_latch;
	logic                ee_latch;
	logic                rd_cmd;
	logic                apb_mapped;
	logic [15:0]         flash_word;
	logic [7:0]          ee_byte;

	assign full_addr = {q.addr_ext, q.addr_hi, q.addr_lo};
	assign waddr     = full_addr[FLASH_AW-1:0];
	assign eaddr     = full_addr[EE_AW-1:0];
	// page number comes from the held address, word within page from the walk counter
	assign walk_waddr = {waddr[FLASH_AW-1:PAGE_AW], q.cnt[PAGE_AW-1:0]}; // [R24]
	assign walk_eaddr = {eaddr[EE_AW-1:EE_PAGE_AW], q.cnt[EE_PAGE_AW-1:0]};
	assign act = {q.s2.action_sel_hi, q.s2.action_sel_lo};
	assign bsp = {q.s2.byte_select_2, q.s2.byte_select_1};
	assign din = q.s2.data_in;

	// edges are taken after the two-stage synchroniser only
	assign strobe_rise = q.s2.action_strobe & ~q.prev_strobe;
	assign latch_rise  = q.s2.page_latch_strobe & ~q.prev_latch;
	assign prog_fall   = ~q.s2.prog_strobe_n & q.prev_prog_n;
	// strobes during a self-timed operation are dropped rather than queued
	assign live = q.enable & ~q.busy; // [R25]

	assign flash_word = flash_mem[waddr];
	assign ee_byte    = ee_mem[eaddr];
	assign rd_cmd = (q.cmd == CMD_FLASH_RD) | (q.cmd == CMD_EE_RD) |
		(q.cmd == CMD_FUSE_RD) | (q.cmd == CMD_SIG_RD);

	assign apb_mapped = (apb_req.paddr == REG_CTRL) | (apb_req.paddr == REG_STATUS) |
		(apb_req.paddr == REG_FUSES) | (apb_req.paddr == REG_CALIB);

	assign apb_rsp.prdata  = q.prdata;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~apb_mapped;

	assign data_out   = q.dout;
	assign data_oe_n  = q.doe_n;
	assign ready_busy = ~q.busy; // [R26]

	always_comb begin
		next_q = q;
		next_q.s1 = pins;
		next_q.s2 = q.s1;
		next_q.prev_strobe = q.s2.action_strobe;
		next_q.prev_latch  = q.s2.page_latch_strobe;
		next_q.prev_prog_n = q.s2.prog_strobe_n;
		flash_latch = 1'b0;
		ee_latch    = 1'b0;

		// loads keep their values until overwritten, so one command serves many locations
		if (live && strobe_rise) begin // [R23]
			case (act) // [R21]
				ACT_ADDR: begin
					case (bsp)
						BSP_LOW:  next_q.addr_lo = din;
						BSP_HIGH: next_q.addr_hi = din; // [R1]
						BSP_EXT:  next_q.addr_ext = din; // [R2]
						default: ;
					endcase
				end
				ACT_DATA: begin
					if (q.s2.byte_select_1) begin
						next_q.data_hi = din;
					end else begin
						next_q.data_lo = din;
					end
				end
				ACT_CMD: begin
					next_q.cmd   = din;
					next_q.armed = (din != CMD_NOP); // [R5]
				end
				default: ;
			endcase
		end

		if (live && latch_rise && q.s2.byte_select_1) begin // [R22]
			flash_latch = (q.cmd == CMD_FLASH_WR);
			ee_latch    = (q.cmd == CMD_EE_WR); // [R6]
		end

		// busy is raised on the edge after the synchronised fall, 2 to 3 cycles in all
		if (live && prog_fall && q.armed) begin // [R17]
			next_q.cnt   = '0;
			next_q.limit = CNT_W'(WRITE_CYCLES - 1); // [R18]
			case (q.cmd)
				CMD_FLASH_WR: begin
					if (bsp == BSP_LOW) begin // [R3]
						next_q.busy = 1'b1;
						next_q.op   = OP_FLASH;
					end
				end
				CMD_EE_WR: begin
					if (bsp == BSP_LOW) begin // [R6]
						next_q.busy = 1'b1;
						next_q.op   = OP_EE;
					end
				end
				CMD_FUSE_WR: begin
					next_q.busy = (bsp != BSP_ALT);
					next_q.op   = OP_FUSE;
					case (bsp) // [R10]
						BSP_LOW:  next_q.fuse_lo = q.data_lo;
						BSP_HIGH: next_q.fuse_hi = q.data_lo;
						BSP_EXT:  next_q.fuse_ext = q.data_lo;
						default: next_q.op = OP_IDLE;
					endcase
				end
				CMD_LOCK_WR: begin
					next_q.busy = 1'b1;
					next_q.op   = OP_LOCK;
					// a lock write can only clear bits: erased ones need chip erase or presetn
					next_q.lock = q.lock & q.data_lo; // [R11] [R13]
					if (q.lock[LOCK_GEN_MSB:LOCK_GEN_LSB] == 2'h0) begin
						next_q.lock[LOCK_BOOT_MSB:LOCK_BOOT_LSB] =
							q.lock[LOCK_BOOT_MSB:LOCK_BOOT_LSB]; // [R12]
					end
				end
				CMD_ERASE: begin
					next_q.busy  = 1'b1;
					next_q.op    = OP_ERASE;
					next_q.limit = CNT_W'(ERASE_CYCLES - 1); // [R19]
				end
				default: ;
			endcase
		end

		if (q.busy) begin
			next_q.cnt = q.cnt + 1'b1;
			if (q.cnt == q.limit) begin // [R18] [R19]
				next_q.busy = 1'b0;
				next_q.op   = OP_IDLE;
				next_q.cnt  = '0;
				// locks clear only once the whole array walk has finished
				if (q.op == OP_ERASE) begin
					next_q.lock = LOCK_RESET; // [R13]
				end
			end
		end

		// read-back; the bus is released three cycles after output enable rises
		next_q.doe_n = ~(q.enable & ~q.s2.output_enable_n & rd_cmd); // [R20]
		next_q.dout  = ERASED_BYTE;
		case (q.cmd)
			CMD_FLASH_RD: next_q.dout = q.s2.byte_select_1 ? flash_word[15:8]
				: flash_word[7:0]; // [R8]
			CMD_EE_RD: next_q.dout = ee_byte; // [R9]
			CMD_FUSE_RD: begin
				case (bsp) // [R14]
					BSP_LOW:  next_q.dout = q.fuse_lo;
					BSP_HIGH: next_q.dout = q.lock;
					BSP_EXT:  next_q.dout = q.fuse_ext;
					default: next_q.dout = q.fuse_hi;
				endcase
			end
			CMD_SIG_RD: begin
				if (q.s2.byte_select_1) begin
					if (q.addr_lo == 8'h00) begin
						next_q.dout = q.calib; // [R16]
					end
				end else begin
					case (q.addr_lo) // [R15]
						8'h00: next_q.dout = SIG_BYTE0;
						8'h01: next_q.dout = SIG_BYTE1;
						8'h02: next_q.dout = SIG_BYTE2;
						default: ;
					endcase
				end
			end
			default: ;
		endcase

		// APB: read data is captured in the setup phase so pready can stay high
		if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			case (apb_req.paddr)
				REG_CTRL:   next_q.prdata = {31'h0000_0000, q.enable};
				REG_STATUS: next_q.prdata = {8'h00, q.lock, q.cmd, 4'h0, q.op, ~q.busy};
				REG_FUSES:  next_q.prdata = {8'h00, q.fuse_ext, q.fuse_hi, q.fuse_lo};
				REG_CALIB:  next_q.prdata = {24'h00_0000, q.calib};
				default:    next_q.prdata = 32'h0000_0000;
			endcase
		end
		if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
			case (apb_req.paddr)
				REG_CTRL:  next_q.enable = apb_req.pwdata[CTRL_EN_BIT];
				REG_CALIB: next_q.calib = apb_req.pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= STATE_RESET;
		end else if (clk_en) begin
			q <= next_q;
		end
	end

	// arrays hold no reset: their content is defined by chip erase
	always_ff @(posedge pclk) begin
		if (clk_en) begin
			if (flash_latch) begin
				page_buf[waddr[PAGE_AW-1:0]] <= {q.data_hi, q.data_lo}; // [R22] [R24]
			end
			if (ee_latch) begin
				ee_buf[eaddr[EE_PAGE_AW-1:0]] <= q.data_lo;
			end
			// one location per cycle keeps the array single-ported
			if (q.busy && q.op == OP_FLASH && q.cnt < CNT_W'(2**PAGE_AW)) begin // [R3]
				flash_mem[walk_waddr] <= page_buf[q.cnt[PAGE_AW-1:0]];
				page_buf[q.cnt[PAGE_AW-1:0]] <= ERASED_WORD;
			end
			if (q.busy && q.op == OP_EE && q.cnt < CNT_W'(2**EE_PAGE_AW)) begin // [R6]
				ee_mem[walk_eaddr] <= ee_buf[q.cnt[EE_PAGE_AW-1:0]];
				ee_buf[q.cnt[EE_PAGE_AW-1:0]] <= ERASED_BYTE;
			end
			if (q.busy && q.op == OP_ERASE) begin // [R19]
				// buffers are cleaned too, so unlatched words of the next page write read erased
				if (q.cnt < CNT_W'(2**PAGE_AW)) begin
					page_buf[q.cnt[PAGE_AW-1:0]] <= ERASED_WORD;
				end
				if (q.cnt < CNT_W'(2**EE_PAGE_AW)) begin
					ee_buf[q.cnt[EE_PAGE_AW-1:0]] <= ERASED_BYTE;
				end
				if (q.cnt < CNT_W'(2**FLASH_AW)) begin
					flash_mem[q.cnt[FLASH_AW-1:0]] <= ERASED_WORD;
				end
				if (q.cnt < CNT_W'(2**EE_AW)) begin
					ee_mem[q.cnt[EE_AW-1:0]] <= ERASED_BYTE;
				end
			end
		end
	end

endmodule

//--- bench/nvm_props.sv
// pin-level timing checks of the programming port, bound into its top module
// assumes pclk is the only clock and presetn the asynchronous reset
module nvm_props #(
	parameter int WRITE_CYCLES = 200,
	parameter int ERASE_CYCLES = 1200
) (
	input logic              pclk,
	input logic              presetn,
	input logic              clk_en,
	input nvm_pkg::apb_req_t apb_req,
	input nvm_pkg::apb_rsp_t apb_rsp,
	input nvm_pkg::pins_t    pins,
	input logic [7:0]        data_out,
	input logic              data_oe_n,
	input logic              ready_busy
);
	import nvm_pkg::*;
	// length of the current busy stretch, so one check covers both windows
	logic [CNT_W-1:0] low_cnt;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_cnt <= '0;
		else if (ready_busy)
			low_cnt <= '0;
		else
			low_cnt <= low_cnt + 1'b1;
	end
	AST_RDY_FALL_CAUSE: assert property ($fell(ready_busy) |-> !$past(pins.prog_strobe_n, 2))
		else $error("ready fell without a program strobe");
	AST_BUSY_MIN: assert property ($fell(ready_busy) |=> !ready_busy [*8])
		else $error("busy stretch too short");
	AST_BUSY_LEN: assert property ($rose(ready_busy) |->
		(low_cnt >= WRITE_CYCLES - 4 && low_cnt <= WRITE_CYCLES + 4) ||
		(low_cnt >= ERASE_CYCLES - 4 && low_cnt <= ERASE_CYCLES + 4))
		else $error("busy length outside its window");
	AST_BUSY_MAX: assert property (!ready_busy |-> low_cnt < ERASE_CYCLES + 4)
		else $error("busy held past the longest operation");
	AST_RDY_HOLD: assert property ($rose(ready_busy) |-> ready_busy [*3])
		else $error("ready dropped without a new strobe");
	AST_OE_FALL_CAUSE: assert property ($fell(data_oe_n) |-> !$past(pins.output_enable_n, 2))
		else $error("bus driven without output enable");
	AST_OE_RELEASE: assert property ($rose(pins.output_enable_n) |-> ##[1:5] data_oe_n)
		else $error("bus not released in time");
	AST_OE_IDLE: assert property (pins.output_enable_n [*6] |-> data_oe_n)
		else $error("bus driven while output enable high");
	AST_SLVERR_PHASE: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
		else $error("bus error outside an access phase");
	cover property ($rose(ready_busy) && low_cnt > WRITE_CYCLES + 8);
	cover property ($rose(ready_busy) && low_cnt < WRITE_CYCLES + 8);
	cover property ($fell(data_oe_n));
endmodule

bind parallel_nvm_programming_port nvm_props #(
	.WRITE_CYCLES(WRITE_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)
) u_nvm_props (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.pins(pins), .data_out(data_out), .data_oe_n(data_oe_n), .ready_busy(ready_busy)
);

//--- bench/nvm_programmer.sv
// behavioural parallel programmer: drives the pin group and shares the data bus
// assumes the device samples its pins through synchronisers on pclk
module nvm_programmer (
	input  logic           pclk,
	output nvm_pkg::pins_t pins,
	input  logic [7:0]     data_out,
	input  logic           data_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import nvm_pkg::*;
	pins_t      p;
	logic       drv;
	logic [7:0] last;
	initial begin
		p = '{action_sel_hi: 1'b1, action_sel_lo: 1'b1, prog_strobe_n: 1'b1,
			output_enable_n: 1'b1, default: '0};
		drv = 1'b1;
	end
	// no pull on the bus: undriven it shows the inverse of its last level
	always_comb begin
		pins = p;
		if (!data_oe_n)
			pins.data_in = data_out;
		else if (!drv)
			pins.data_in = ~last;
	end
	always @(posedge pclk) last <= pins.data_in;
	task automatic step(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// selects and data held 5 edges past each strobe so synchronised samples agree
	task automatic act(input logic [1:0] a, input logic [1:0] bp, input logic [7:0] d);
		@(posedge pclk);
		{p.action_sel_hi, p.action_sel_lo} <= a;
		{p.byte_select_2, p.byte_select_1} <= bp;
		p.data_in <= d;
		drv <= 1'b1;
		step(2);
		p.action_strobe <= 1'b1;
		step(4);
		p.action_strobe <= 1'b0;
		step(5);
		{p.action_sel_hi, p.action_sel_lo} <= 2'h3;
	endtask
	task automatic latch();
		@(posedge pclk);
		p.byte_select_1 <= 1'b1;
		step(2);
		p.page_latch_strobe <= 1'b1;
		step(4);
		p.page_latch_strobe <= 1'b0;
		step(5);
	endtask
	task automatic prog(input logic [1:0] bp);
		@(posedge pclk);
		{p.byte_select_2, p.byte_select_1} <= bp;
		step(2);
		p.prog_strobe_n <= 1'b0;
		step(4);
		p.prog_strobe_n <= 1'b1;
		step(5);
	endtask
	task automatic rd(input logic [1:0] bp, output logic [7:0] d);
		@(posedge pclk);
		{p.byte_select_2, p.byte_select_1} <= bp;
		drv <= 1'b0;
		p.output_enable_n <= 1'b0;
		step(8);
		d = pins.data_in;
		p.output_enable_n <= 1'b1;
		step(8);
	endtask
endmodule

//--- bench/tb_parallel_nvm_programming_port.sv
// self-checking bench for the programming port, driven through the programmer model
// assumes shortened busy counts and a 10-bit flash word address
module tb_parallel_nvm_programming_port;
	timeunit 1ns;
	timeprecision 1ns;
	import nvm_pkg::*;
	localparam logic [7:0] SIG [3] = '{8'h12, 8'h34, 8'h56}; // arbitrary value
	logic        pclk, presetn, clk_en, doe_n, rdy, er;
	apb_req_t    req;
	apb_rsp_t    rsp;
	pins_t       pins;
	logic [7:0]  dout, b;
	logic [31:0] rd;
	int          fails, checks, cyc;
	logic [1:0]  fp [3] = '{BSP_LOW, BSP_HIGH, BSP_EXT};
	logic [1:0]  fr [3] = '{BSP_LOW, BSP_ALT, BSP_EXT};
	logic [7:0]  fv [3] = '{8'hE1, 8'hD2, 8'hC3};
	logic [7:0]  lv [3] = '{8'hF3, 8'hFC, 8'hC3};
	logic [7:0]  le [3] = '{8'hF3, 8'hF0, 8'hF0};
	parallel_nvm_programming_port #(.FLASH_AW(10), .EE_AW(8), .WRITE_CYCLES(200),
		.ERASE_CYCLES(1200), .SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2])
	) u_parallel_nvm_programming_port (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.apb_req(req), .apb_rsp(rsp), .pins(pins), .data_out(dout), .data_oe_n(doe_n),
		.ready_busy(rdy));
	nvm_programmer pm (.pclk(pclk), .pins(pins), .data_out(dout), .data_oe_n(doe_n));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails = fails + 1;
			report_and_stop();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
		@(posedge pclk);
		req.penable <= 1'b1;
		do @(posedge pclk); while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	// busy must already show when the strobe task returns
	task automatic wait_rdy();
		chk("busy after strobe", 32'h0, 32'(rdy));
		while (rdy !== 1'b1) @(posedge pclk);
	endtask
	initial begin
		req = '0;
		clk_en = 1'b1;
		presetn = 1'b0;
		{fails, checks, cyc} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// chip erase first so arrays and page buffers start from erased contents
		pm.act(ACT_CMD, BSP_LOW, CMD_ERASE);
		pm.prog(BSP_LOW);
		wait_rdy();
		pm.act(ACT_CMD, BSP_LOW, CMD_SIG_RD);
		for (int i = 0; i < 3; i++) begin
			pm.act(ACT_ADDR, BSP_LOW, 8'(i));
			pm.rd(BSP_LOW, b);
			chk("signature", 32'(SIG[i]), 32'(b));
		end
		pm.act(ACT_ADDR, BSP_LOW, 8'h00);
		pm.rd(BSP_HIGH, b);
		chk("calibration", 32'(CALIB_RESET), 32'(b));
		pm.act(ACT_CMD, BSP_LOW, CMD_FUSE_WR);
		for (int i = 0; i < 3; i++) begin
			pm.act(ACT_DATA, BSP_LOW, fv[i]);
			pm.prog(fp[i]);
			wait_rdy();
		end
		pm.act(ACT_CMD, BSP_LOW, CMD_FUSE_RD);
		for (int i = 0; i < 3; i++) begin
			pm.rd(fr[i], b);
			chk("fuse", 32'(fv[i]), 32'(b));
		end
		for (int i = 0; i < 3; i++) begin
			pm.act(ACT_CMD, BSP_LOW, CMD_LOCK_WR);
			pm.act(ACT_DATA, BSP_LOW, lv[i]);
			pm.prog(BSP_LOW);
			wait_rdy();
			pm.act(ACT_CMD, BSP_LOW, CMD_FUSE_RD);
			pm.rd(BSP_HIGH, b);
			chk("lock", 32'(le[i]), 32'(b));
		end
		pm.act(ACT_CMD, BSP_LOW, CMD_FLASH_WR);
		pm.act(ACT_ADDR, BSP_EXT, 8'h00);
		pm.act(ACT_ADDR, BSP_HIGH, 8'h01);
		for (int i = 0; i < 2; i++) begin
			pm.act(ACT_ADDR, BSP_LOW, 8'h85 + 8'(i));
			pm.act(ACT_DATA, BSP_LOW, 8'hA0 + 8'(i));
			pm.act(ACT_DATA, BSP_HIGH, 8'h50 + 8'(i));
			pm.latch();
		end
		pm.prog(BSP_LOW);
		wait_rdy();
		pm.act(ACT_CMD, BSP_LOW, CMD_NOP);
		pm.prog(BSP_LOW);
		chk("ready after nop strobe", 32'h1, 32'(rdy));
		pm.act(ACT_CMD, BSP_LOW, CMD_FLASH_RD);
		for (int i = 0; i < 3; i++) begin
			pm.act(ACT_ADDR, BSP_LOW, 8'h85 + 8'(i));
			pm.rd(BSP_LOW, b);
			chk("flash low", (i < 2) ? 32'hA0 + 32'(i) : 32'hFF, 32'(b));
			pm.rd(BSP_HIGH, b);
			chk("flash high", (i < 2) ? 32'h50 + 32'(i) : 32'hFF, 32'(b));
		end
		pm.act(ACT_CMD, BSP_LOW, CMD_EE_WR);
		pm.act(ACT_ADDR, BSP_HIGH, 8'h00);
		pm.act(ACT_ADDR, BSP_LOW, 8'h0B);
		pm.act(ACT_DATA, BSP_LOW, 8'h77);
		pm.latch();
		pm.prog(BSP_LOW);
		wait_rdy();
		pm.act(ACT_CMD, BSP_LOW, CMD_EE_RD);
		pm.rd(BSP_LOW, b);
		chk("eeprom", 32'h77, 32'(b));
		pm.act(ACT_CMD, BSP_LOW, CMD_ERASE);
		pm.prog(BSP_LOW);
		wait_rdy();
		pm.act(ACT_CMD, BSP_LOW, CMD_FUSE_RD);
		pm.rd(BSP_HIGH, b);
		chk("lock after erase", 32'hFF, 32'(b));
		pm.act(ACT_CMD, BSP_LOW, CMD_FLASH_RD);
		pm.act(ACT_ADDR, BSP_HIGH, 8'h01);
		pm.act(ACT_ADDR, BSP_LOW, 8'h85);
		pm.rd(BSP_LOW, b);
		chk("erased flash", 32'hFF, 32'(b));
		apb(1'b0, REG_CTRL, 32'h0);
		chk("port enable", 32'h1, rd);
		apb(1'b0, REG_FUSES, 32'h0);
		chk("fuse register", 32'h00C3_D2E1, rd);
		apb(1'b1, REG_CALIB, 32'h37);
		apb(1'b0, REG_CALIB, 32'h0);
		chk("calibration register", 32'h37, rd);
		apb(1'b0, 12'h040, 32'h0);
		chk("unmapped error", 32'h1, 32'(er));
		// with the port disabled a command load must be ignored
		apb(1'b1, REG_CTRL, 32'h0);
		pm.act(ACT_CMD, BSP_LOW, CMD_NOP);
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status register", 32'h00FF_0201, rd);
		report_and_stop();
	end
endmodule
